// File: rtl/adp_pkg.sv
// Package: register map, field positions, reset values and timing figures
package adp_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_PTR_HIGH = 8'h83;
  localparam logic [7:0] SFR_PTR_LOW = 8'h84;
  localparam logic [7:0] SFR_AUX = 8'h8E;
  localparam logic [7:0] SFR_AUX1 = 8'hA2;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  // ----------------------------------------------------------------
  // Reset values and writable bits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_AUX = 8'h0C;
  localparam logic [7:0] RST_AUX1 = 8'h00;
  localparam logic [7:0] RST_PSW = 8'h00;
  localparam logic [7:0] AUX_WMASK = 8'h2F;
  localparam logic [7:0] AUX1_WMASK = 8'h09;
  localparam logic [7:0] PSW_WMASK = 8'hFE;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AUX_STRETCH = 5;
  localparam int AUX_SIZE_LO = 2;
  localparam int AUX_TARGET = 1;
  localparam int AUX_GATING = 0;
  localparam int AUX1_SELECT = 0;
  localparam int AUX1_ZERO = 2;
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_F1 = 1;
  localparam int PSW_PAR = 0;
  // ----------------------------------------------------------------
  // Timing in clock periods
  // ----------------------------------------------------------------
  localparam int STROBE_NORMAL = 3;
  localparam int STROBE_STRETCH = 15;
  localparam int ALE_DIV_STD = 6;
  localparam int ALE_DIV_X2 = 3;
  // Bus cycle states
  typedef enum logic [1:0] {
    XS_IDLE = 2'b00,
    XS_ADDR = 2'b01,
    XS_STRB = 2'b10,
    XS_DONE = 2'b11
  } adp_xstate_e;
  // Address falls into the mapped part of the on-chip expanded RAM
  function automatic logic adp_xram_hit(input logic [15:0] a,
                                        input logic [1:0] size);
    return (a[15:10] == 6'h00) && (a[9:8] <= size);
  endfunction
endpackage

// File: rtl/adp_if.sv
// Interfaces between the control top and its pointer bank and timer
`timescale 1ns/100ps
`default_nettype none
// Pointer bank carrier
interface adp_ptr_if;
  logic sel;
  logic wr_high;
  logic wr_low;
  logic inc;
  logic load;
  logic [7:0] wdata;
  logic [15:0] load_val;
  logic [15:0] ptr;
  modport bank (input sel, wr_high, wr_low, inc, load, wdata, load_val,
                output ptr);
  modport ctrl (output sel, wr_high, wr_low, inc, load, wdata, load_val,
                input ptr);
endinterface
// Strobe and address latch timer carrier
interface adp_tmr_if;
  logic load;
  logic long_mode;
  logic x2;
  logic fin;
  logic tick;
  modport timer (input load, long_mode, x2, output fin, tick);
  modport ctrl (output load, long_mode, x2, input fin, tick);
endinterface
`default_nettype wire

// File: rtl/adp_ptr_bank.sv
// Two data pointers behind one shared pair of byte registers
`timescale 1ns/100ps
`default_nettype none
module adp_ptr_bank (
  input wire logic clock,
  input wire logic rst_n,
  adp_ptr_if.bank pif
);
  logic [15:0] ptr_q [2];
  logic [15:0] cur;
  logic [15:0] other;
  logic [15:0] next_cur;

  // Only the selected pointer is ever visible or changed
  assign cur = ptr_q[pif.sel]; // RQ6
  assign other = ptr_q[~pif.sel];
  assign pif.ptr = cur;
  assign next_cur = pif.load ? pif.load_val :
                    pif.inc ? cur + adp_pkg::WORD_ONE :
                    pif.wr_high ? {pif.wdata, cur[7:0]} :
                    pif.wr_low ? {cur[15:8], pif.wdata} : cur;

  // Update selected slot; the other slot is left untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q[0] <= adp_pkg::WORD_ZERO;
      ptr_q[1] <= adp_pkg::WORD_ZERO;
    end else begin
      ptr_q[pif.sel] <= next_cur; // RQ9
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  unselected_kept_a: assert property ( // RQ9
    (pif.inc || pif.load || pif.wr_high || pif.wr_low)
    |=> ptr_q[~$past(pif.sel)] == $past(other))
    else $error("Unselected pointer changed");
  selected_load_a: assert property ( // RQ6
    pif.load |=> ptr_q[$past(pif.sel)] == $past(pif.load_val))
    else $error("Selected pointer did not take load value");
endmodule
`default_nettype wire

// File: rtl/adp_strobe_timer.sv
// Strobe width counter and free running address latch divider
`timescale 1ns/100ps
`default_nettype none
module adp_strobe_timer #(
  parameter int STROBE_NORMAL = adp_pkg::STROBE_NORMAL,
  parameter int STROBE_STRETCH = adp_pkg::STROBE_STRETCH,
  parameter int ALE_DIV_STD = adp_pkg::ALE_DIV_STD,
  parameter int ALE_DIV_X2 = adp_pkg::ALE_DIV_X2
) (
  input wire logic clock,
  input wire logic rst_n,
  adp_tmr_if.timer tif
);
  localparam logic [3:0] LOAD_SHORT = 4'(STROBE_NORMAL - 1);
  localparam logic [3:0] LOAD_LONG = 4'(STROBE_STRETCH - 1);
  localparam logic [2:0] DIV_STD = 3'(ALE_DIV_STD - 1);
  localparam logic [2:0] DIV_X2 = 3'(ALE_DIV_X2 - 1);
  logic [3:0] cnt;
  logic run;
  logic [2:0] div_q;
  logic [3:0] next_cnt;
  logic [2:0] next_div;

  // Stretch swaps a 3 period strobe for a 15 period one
  assign next_cnt = tif.load ? (tif.long_mode ? LOAD_LONG : LOAD_SHORT) // RQ3
                    : (cnt == 4'h0) ? cnt : cnt - 4'h1;
  assign tif.fin = run && (cnt == 4'h0);
  // Divider wraps at 6, or at 3 in double speed mode
  assign next_div = (div_q == 3'h0) ? (tif.x2 ? DIV_X2 : DIV_STD) // RQ16
                    : div_q - 3'h1;
  assign tif.tick = (div_q == 3'h0);

  // Counter and divider registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      run <= 1'b0;
      div_q <= 3'h0;
    end else begin
      cnt <= next_cnt;
      run <= tif.load || (run && !tif.fin);
      div_q <= next_div;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  short_count_a: assert property ( // RQ3
    tif.load && !tif.long_mode |-> ##3 tif.fin)
    else $error("Normal strobe count is not 3");
  long_count_a: assert property ( // RQ3
    tif.load && tif.long_mode |-> ##15 tif.fin)
    else $error("Stretched strobe count is not 15");
  tick_spacing_a: assert property ( // RQ16
    tif.tick |=> !tif.tick ##1 !tif.tick)
    else $error("Latch strobe ticks too close");
endmodule
`default_nettype wire

// File: rtl/adp_aux_ctrl.sv
// Auxiliary control, status word and dual pointer register bank
// Summary of operation
// [RQ1] Stretch bit lengthens the read strobe of external data moves.
// [RQ2] Stretch bit lengthens the write strobe of external data moves.
// [RQ3] Strobe width is 3 clocks normally, 15 clocks when stretched.
// [RQ4] Register-indirect moves put the port latch on the upper address.
// [RQ5] Two 16-bit pointers share the byte registers at 83h and 84h.
// [RQ6] Pointer select bit picks which pointer answers every access.
// [RQ7] Incrementing the select register toggles the select bit.
// [RQ8] Bit above the select bit always reads zero.
// [RQ9] Loads and increments touch only the selected pointer.
// [RQ10] Parity flag follows the accumulator's odd count of ones.
// [RQ11] Overflow flag is set by arithmetic signed overflow.
// [RQ12] Two free user flags in the status word.
// [RQ13] Bank select maps R0-R7 to 00h, 08h, 10h or 18h.
// [RQ14] Status word resets to zero.
// [RQ15] Target bit picks on-chip expanded RAM or external memory.
// [RQ16] Latch strobe free runs at 1/6 or 1/3, or only during moves.
// [RQ17] Size field sets how much expanded RAM is mapped, default 1024.
// [RQ18] Auxiliary register resets to size 11, other bits zero.
`timescale 1ns/100ps
`default_nettype none
module adp_aux_ctrl (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_inc,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] acc,
  input wire logic alu_we,
  input wire logic alu_cy,
  input wire logic alu_ac,
  input wire logic alu_ov,
  input wire logic ptr_inc,
  input wire logic ptr_load,
  input wire logic [15:0] ptr_load_val,
  input wire logic x2_mode,
  input wire logic xmov_start,
  input wire logic xmov_write,
  input wire logic xmov_ri,
  input wire logic [7:0] ri_value,
  input wire logic [7:0] xmov_wdata,
  input wire logic [7:0] port_high_latch,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] upper_address_port,
  output logic [7:0] ad_out,
  output logic ad_oe,
  input wire logic [7:0] ad_in,
  output logic [7:0] xmov_rdata,
  output logic xmov_done,
  output logic xmov_busy,
  output logic xram_req,
  output logic xram_write,
  output logic [9:0] xram_addr,
  output logic [7:0] xram_wdata,
  output logic [4:0] bank_base,
  output logic [15:0] data_pointer,
  output logic pointer_select
);
  // ----------------------------------------------------------------
  // Registers and wires
  // ----------------------------------------------------------------
  adp_ptr_if pif ();
  adp_tmr_if tif ();
  adp_pkg::adp_xstate_e state;
  adp_pkg::adp_xstate_e next_state;
  logic [7:0] aux;
  logic [7:0] aux1;
  logic [7:0] program_status_word;
  logic wr_q;
  logic long_q;
  logic [7:0] psw_view;
  logic [7:0] aux1_view;
  logic [7:0] rd_mux;
  logic [7:0] wval;
  logic we;
  logic hit_aux;
  logic hit_aux1;
  logic hit_psw;
  logic [7:0] psw_base;
  logic [7:0] next_psw;
  logic [15:0] addr16;
  logic internal;
  logic start_ext;
  logic next_ale;
  logic next_rd_n;
  logic next_wr_n;
  logic [7:0] next_upper;
  logic [7:0] next_ad_out;
  logic next_ad_oe;
  logic [7:0] next_rdata;
  logic next_done;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  adp_ptr_bank u_ptr (
    .clock(clock),
    .rst_n(rst_n),
    .pif(pif.bank)
  );
  adp_strobe_timer u_tmr (
    .clock(clock),
    .rst_n(rst_n),
    .tif(tif.timer)
  );

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Parity is live from the accumulator, never stored
  assign psw_view = {program_status_word[7:1], ^acc}; // RQ10
  // Reserved and always-zero bits masked so an increment only toggles
  assign aux1_view = aux1 & adp_pkg::AUX1_WMASK; // RQ8
  assign rd_mux = (sfr_addr == adp_pkg::SFR_PTR_HIGH) ? pif.ptr[15:8] :
                  (sfr_addr == adp_pkg::SFR_PTR_LOW) ? pif.ptr[7:0] : // RQ5
                  (sfr_addr == adp_pkg::SFR_AUX) ? aux :
                  (sfr_addr == adp_pkg::SFR_AUX1) ? aux1_view :
                  (sfr_addr == adp_pkg::SFR_PSW) ? psw_view :
                  adp_pkg::BYTE_ZERO;
  // An increment is a read-modify-write through the same decode
  assign wval = sfr_inc ? rd_mux + adp_pkg::BYTE_ONE : sfr_wdata; // RQ7
  assign we = sfr_wr || sfr_inc;
  assign hit_aux = we && (sfr_addr == adp_pkg::SFR_AUX);
  assign hit_aux1 = we && (sfr_addr == adp_pkg::SFR_AUX1);
  assign hit_psw = we && (sfr_addr == adp_pkg::SFR_PSW);
  // Arithmetic flag updates win over a software write in the same cycle
  assign psw_base = hit_psw ? (wval & adp_pkg::PSW_WMASK) : program_status_word; // RQ12
  assign next_psw = alu_we ? {alu_cy, alu_ac, psw_base[5:3], alu_ov, // RQ11
                              psw_base[1:0]} : psw_base;

  // Pointer bank steering
  assign pif.sel = aux1[adp_pkg::AUX1_SELECT]; // RQ6
  assign pif.wr_high = we && (sfr_addr == adp_pkg::SFR_PTR_HIGH); // RQ5
  assign pif.wr_low = we && (sfr_addr == adp_pkg::SFR_PTR_LOW); // RQ5
  assign pif.wdata = wval;
  assign pif.inc = ptr_inc;
  assign pif.load = ptr_load;
  assign pif.load_val = ptr_load_val;

  // ----------------------------------------------------------------
  // Move routing
  // ----------------------------------------------------------------
  // Ri moves take the upper byte from the port latch, not the pointer
  assign addr16 = xmov_ri ? {port_high_latch, ri_value} : pif.ptr; // RQ4
  // Addresses above the mapped size fall through to external memory
  assign internal = !aux[adp_pkg::AUX_TARGET] && // RQ15
                    adp_pkg::adp_xram_hit(addr16, // RQ17
                    aux[adp_pkg::AUX_SIZE_LO+1:adp_pkg::AUX_SIZE_LO]);
  // An external request while a bus cycle is in flight is dropped
  assign start_ext = xmov_start && !internal &&
                     (state == adp_pkg::XS_IDLE);
  assign tif.load = (state == adp_pkg::XS_ADDR);
  assign tif.long_mode = long_q;
  assign tif.x2 = x2_mode;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Software registers; not bit addressable, byte writes only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aux <= adp_pkg::RST_AUX; // RQ18
      aux1 <= adp_pkg::RST_AUX1;
      program_status_word <= adp_pkg::RST_PSW; // RQ14
    end else begin
      if (hit_aux) begin
        aux <= wval & adp_pkg::AUX_WMASK;
      end
      if (hit_aux1) begin
        aux1 <= wval & adp_pkg::AUX1_WMASK; // RQ7
      end
      program_status_word <= next_psw;
    end
  end

  // Read data, pointer view and bank base, one cycle behind
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= adp_pkg::BYTE_ZERO;
      data_pointer <= adp_pkg::WORD_ZERO;
      bank_base <= 5'h00;
    end else begin
      if (sfr_rd) begin
        sfr_rdata <= rd_mux;
      end
      data_pointer <= pif.ptr;
      bank_base <= {program_status_word[adp_pkg::PSW_RS_LO+1:adp_pkg::PSW_RS_LO], 3'h0}; // RQ13
    end
  end
  assign pointer_select = aux1[adp_pkg::AUX1_SELECT];

  // Internal expanded RAM request, handed to the RAM in one cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      xram_req <= 1'b0;
      xram_write <= 1'b0;
      xram_addr <= 10'h000;
      xram_wdata <= adp_pkg::BYTE_ZERO;
    end else begin
      xram_req <= xmov_start && internal; // RQ15
      xram_write <= xmov_write;
      xram_addr <= addr16[9:0];
      xram_wdata <= xmov_wdata;
    end
  end

  // ----------------------------------------------------------------
  // External bus cycle
  // ----------------------------------------------------------------
  // Next values of the bus pins from the cycle state
  always_comb begin
    next_state = state;
    next_ale = 1'b0;
    next_rd_n = rd_n;
    next_wr_n = wr_n;
    next_upper = upper_address_port;
    next_ad_out = ad_out;
    next_ad_oe = ad_oe;
    next_rdata = xmov_rdata;
    next_done = 1'b0;
    case (state)
      adp_pkg::XS_IDLE: begin
        // Free running strobe only when gating is off
        next_ale = start_ext || (!aux[adp_pkg::AUX_GATING] && tif.tick); // RQ16
        if (start_ext) begin
          next_state = adp_pkg::XS_ADDR;
          next_upper = addr16[15:8]; // RQ4
          next_ad_out = addr16[7:0];
          next_ad_oe = 1'b1;
        end
      end
      adp_pkg::XS_ADDR: begin
        next_state = adp_pkg::XS_STRB;
        next_ad_out = wr_q ? xmov_wdata : adp_pkg::BYTE_ZERO;
        next_ad_oe = wr_q;
        next_rd_n = wr_q; // RQ1
        next_wr_n = !wr_q; // RQ2
      end
      adp_pkg::XS_STRB: begin
        if (tif.fin) begin
          next_state = adp_pkg::XS_DONE;
          next_rd_n = 1'b1;
          next_wr_n = 1'b1;
          next_rdata = wr_q ? xmov_rdata : ad_in;
          next_done = 1'b1;
        end
      end
      adp_pkg::XS_DONE: begin
        next_state = adp_pkg::XS_IDLE;
        next_ad_oe = 1'b0;
      end
      default: begin
        next_state = adp_pkg::XS_IDLE;
      end
    endcase
  end

  // Bus pin registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= adp_pkg::XS_IDLE;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      upper_address_port <= adp_pkg::BYTE_ZERO;
      ad_out <= adp_pkg::BYTE_ZERO;
      ad_oe <= 1'b0;
      xmov_rdata <= adp_pkg::BYTE_ZERO;
      xmov_done <= 1'b0;
      xmov_busy <= 1'b0;
    end else begin
      state <= next_state;
      ale <= next_ale;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      upper_address_port <= next_upper;
      ad_out <= next_ad_out;
      ad_oe <= next_ad_oe;
      xmov_rdata <= next_rdata;
      xmov_done <= next_done;
      xmov_busy <= (next_state != adp_pkg::XS_IDLE);
    end
  end

  // Direction and width choice are frozen for the whole cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      long_q <= 1'b0;
    end else if (start_ext) begin
      wr_q <= xmov_write;
      long_q <= aux[adp_pkg::AUX_STRETCH]; // RQ1
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] low_cnt;
  logic [4:0] exp_width;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 5'h00;
    end else begin
      low_cnt <= (!rd_n || !wr_n) ? low_cnt + 5'h01 : 5'h00;
    end
  end
  assign exp_width = long_q ? 5'(adp_pkg::STROBE_STRETCH) :
                     5'(adp_pkg::STROBE_NORMAL);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  read_width_a: assert property ($rose(rd_n) |-> low_cnt == exp_width) // RQ1
    else $error("Read strobe width wrong");
  write_width_a: assert property ($rose(wr_n) |-> low_cnt == exp_width) // RQ2
    else $error("Write strobe width wrong");
  ri_upper_a: assert property (start_ext && xmov_ri // RQ4
    |=> upper_address_port == $past(port_high_latch))
    else $error("Upper address not from port latch");
  ptr_read_a: assert property ( // RQ5
    sfr_rd && sfr_addr == adp_pkg::SFR_PTR_HIGH
    |=> sfr_rdata == $past(pif.ptr[15:8]))
    else $error("High pointer byte read wrong");
  select_toggle_a: assert property ( // RQ7
    sfr_inc && sfr_addr == adp_pkg::SFR_AUX1
    |=> pointer_select != $past(pointer_select))
    else $error("Increment did not toggle select");
  zero_bit_a: assert property ( // RQ8
    sfr_rd && sfr_addr == adp_pkg::SFR_AUX1
    |=> !sfr_rdata[adp_pkg::AUX1_ZERO])
    else $error("Always-zero bit read as one");
  parity_read_a: assert property ( // RQ10
    sfr_rd && sfr_addr == adp_pkg::SFR_PSW
    |=> sfr_rdata[adp_pkg::PSW_PAR] == $past(^acc))
    else $error("Parity flag wrong");
  overflow_set_a: assert property ( // RQ11
    alu_we && alu_ov |=> program_status_word[adp_pkg::PSW_OV])
    else $error("Overflow flag not set");
  user_flag_a: assert property ( // RQ12
    sfr_wr && !alu_we && sfr_addr == adp_pkg::SFR_PSW
    |=> program_status_word[adp_pkg::PSW_F0] == $past(sfr_wdata[adp_pkg::PSW_F0]) &&
        program_status_word[adp_pkg::PSW_F1] == $past(sfr_wdata[adp_pkg::PSW_F1]))
    else $error("User flag write lost");
  bank_map_a: assert property ( // RQ13
    ##1 bank_base == {$past(program_status_word[4:3]), 3'h0})
    else $error("Bank base wrong");
  xram_route_a: assert property ( // RQ15
    xmov_start && internal |=> xram_req && !xmov_busy)
    else $error("Internal move went external");
  ale_gated_a: assert property ( // RQ16
    state == adp_pkg::XS_IDLE && !start_ext && aux[adp_pkg::AUX_GATING]
    |=> !ale)
    else $error("Latch strobe emitted while gated");
endmodule
`default_nettype wire

// File: verif/adp_xmem_model.sv
// Behavioural external data memory on the multiplexed bus
`timescale 1ns/100ps
`default_nettype none
module adp_xmem_model (
  input wire logic rst_n,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] upper_address_port,
  input wire logic [7:0] ad_out,
  output logic [7:0] ad_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr = 16'h0000;
  // Latch address a little after the strobe edge to dodge the update race
  always @(posedge ale) begin
    #1 addr = {upper_address_port, ad_out};
  end
  // Store on the closing edge of the write strobe
  always @(posedge wr_n) begin
    if (rst_n === 1'b1) mem[addr] = ad_out;
  end
  // Released bus shows the inverse so stale data never passes
  assign ad_in = rd_n ? ~mem[addr] : mem[addr];
endmodule
`default_nettype wire

// File: verif/adp_aux_ctrl_tb.sv
// Self-checking bench for the auxiliary control block
`timescale 1ns/100ps
`default_nettype none
module adp_aux_ctrl_tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr = 1'b0, sfr_inc = 1'b0, sfr_rd = 1'b0, alu_we = 1'b0;
  logic alu_cy = 1'b0, alu_ac = 1'b0, alu_ov = 1'b0, ptr_inc = 1'b0;
  logic ptr_load = 1'b0, x2_mode = 1'b0, xmov_start = 1'b0;
  logic xmov_write = 1'b0, xmov_ri = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, acc = 8'h00;
  logic [7:0] ri_value = 8'h20, xmov_wdata = 8'h00;
  logic [7:0] port_high_latch = 8'h77;
  logic [15:0] ptr_load_val = 16'h0000;
  logic ale, rd_n, wr_n, ad_oe, xmov_done, xmov_busy, xram_req;
  logic xram_write, pointer_select;
  logic [7:0] sfr_rdata, upper_address_port, ad_out, ad_in, xmov_rdata;
  logic [7:0] xram_wdata;
  logic [9:0] xram_addr;
  logic [4:0] bank_base;
  logic [15:0] data_pointer;
  int mismatches = 0;
  int checks_done = 0;
  adp_aux_ctrl u_adp_aux_ctrl (.*);
  adp_xmem_model u_adp_xmem_model (.rst_n, .ale, .rd_n, .wr_n,
    .upper_address_port, .ad_out, .ad_in);
  // 10 MHz clock
  always #50 clock = ~clock;
  task automatic chk(input string nm, input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One register access: 0 write, 1 increment, 2 read
  task automatic sfr(input int op, input logic [7:0] a, d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = (op == 0);
    sfr_inc = (op == 1);
    sfr_rd = (op == 2);
    @(negedge clock);
    {sfr_wr, sfr_inc, sfr_rd} = 3'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    sfr(2, a, 8'h00);
    @(negedge clock);
    v = sfr_rdata;
  endtask
  task automatic t_reset();
    logic [7:0] v;
    rd(8'h8E, v);
    chk("aux", v, 8'h0C);
    rd(8'hD0, v);
    chk("status", v, 8'h00);
  endtask
  task automatic t_ptr();
    logic [7:0] v;
    sfr(0, 8'h83, 8'h12);
    sfr(0, 8'h84, 8'h34);
    sfr(1, 8'hA2, 8'h00);
    sfr(0, 8'h83, 8'hAB);
    sfr(0, 8'h84, 8'hFF);
    @(negedge clock) ptr_inc = 1'b1;
    @(negedge clock) ptr_inc = 1'b0;
    rd(8'h83, v);
    chk("ptr1_hi", v, 8'hAC);
    chk("ptr", data_pointer, 16'hAC00);
    chk("sel", pointer_select, 1'b1);
    sfr(0, 8'hA2, 8'h0F);
    rd(8'hA2, v);
    chk("aux1", v, 8'h09);
    sfr(1, 8'hA2, 8'h00);
    rd(8'hA2, v);
    chk("aux1_inc", v, 8'h08);
    chk("ptr0", data_pointer, 16'h1234);
  endtask
  task automatic t_status();
    logic [7:0] v;
    acc = 8'h07;
    sfr(0, 8'hD0, 8'h38);
    rd(8'hD0, v);
    chk("status_w", v, 8'h39);
    sfr(0, 8'hD0, 8'h22);
    acc = 8'h03;
    alu_ov = 1'b1;
    @(negedge clock) alu_we = 1'b1;
    @(negedge clock) alu_we = 1'b0;
    rd(8'hD0, v);
    chk("status_ov", v, 8'h26);
    for (int i = 0; i < 4; i++) begin
      sfr(0, 8'hD0, 8'(i * 8));
      @(negedge clock);
      chk("bank", 16'(bank_base), 16'(i * 8));
    end
  endtask
  // External or internal indirect move, strobe width measured
  task automatic mv(input logic w, ri, input logic [7:0] d,
                    input int ext, wd, output logic [7:0] q);
    int n, a, r, dn, b, o;
    @(negedge clock);
    xmov_start = 1'b1;
    xmov_write = w;
    xmov_ri = ri;
    xmov_wdata = d;
    @(negedge clock);
    xmov_start = 1'b0;
    {n, a, r, dn, b, o} = 192'h0;
    repeat (24) begin
      if (dn == 0) begin
        n += int'(!rd_n || !wr_n);
        b += int'(xmov_busy);
        o += int'(ad_oe);
        a += int'(ale);
        r += int'(xram_req);
        dn += int'(xmov_done);
      end
      @(negedge clock);
    end
    q = xmov_rdata;
    chk("strobe", 16'(n), 16'(wd));
    chk("done", 16'(dn), 16'(ext));
    chk("ale_mv", 16'(a), 16'(ext));
    chk("xreq", 16'(r), 16'(1 - ext));
    // Busy spans address, strobe and closing cycle; a read frees AD early
    chk("busy", 16'(b), 16'(ext * (wd + 2)));
    chk("ad_oe", 16'(o), 16'(ext == 0 ? 0 : w ? wd + 2 : 1));
  endtask
  task automatic t_move();
    logic [7:0] q;
    ptr_load_val = 16'h5A10;
    @(negedge clock) ptr_load = 1'b1;
    @(negedge clock) ptr_load = 1'b0;
    for (int s = 0; s < 2; s++) begin
      sfr(0, 8'h8E, s ? 8'h2F : 8'h0F);
      mv(1'b1, 1'b0, 8'hC3 + 8'(s), 1, s ? 15 : 3, q);
      chk("up_ptr", upper_address_port, 8'h5A);
      mv(1'b0, 1'b0, 8'h00, 1, s ? 15 : 3, q);
      chk("rdata", q, 8'hC3 + 8'(s));
      mv(1'b1, 1'b1, 8'h96 - 8'(s), 1, s ? 15 : 3, q);
      chk("up_ri", upper_address_port, 8'h77);
      mv(1'b0, 1'b1, 8'h00, 1, s ? 15 : 3, q);
      chk("rdata_ri", q, 8'h96 - 8'(s));
    end
    port_high_latch = 8'h01;
    sfr(0, 8'h8E, 8'h0D);
    mv(1'b0, 1'b1, 8'h00, 0, 0, q);
    chk("xwr", xram_write, 1'b0);
    chk("xaddr", xram_addr, 10'h120);
    mv(1'b1, 1'b1, 8'h3C, 0, 0, q);
    chk("xwdata", xram_wdata, 8'h3C);
    chk("xwr2", xram_write, 1'b1);
    sfr(0, 8'h8E, 8'h01);
    mv(1'b1, 1'b1, 8'h5E, 1, 3, q);
  endtask
  task automatic t_ale();
    int a;
    for (int m = 0; m < 3; m++) begin
      sfr(0, 8'h8E, m == 2 ? 8'h0D : 8'h0C);
      x2_mode = (m == 1);
      repeat (8) @(negedge clock);
      a = 0;
      repeat (24) begin
        @(negedge clock);
        a += int'(ale);
      end
      chk("ale_free", 16'(a), m == 0 ? 16'h4 : m == 1 ? 16'h8 : 16'h0);
    end
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    t_ptr();
    t_status();
    t_move();
    t_ale();
    // Mid-run reset must bring back the defaults after registers moved
    @(negedge clock) rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    chk("ptr_rst", data_pointer, 16'h0000);
    give_verdict();
  end
  // Watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #500000;
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
